// ===== jtag_flash_defines.vh
// constants for the jtag flash data and address port
`ifndef JTAG_FLASH_DEFINES_VH
`define JTAG_FLASH_DEFINES_VH
// data window layout
`define DW_WIDTH        10
`define DW_RESET        10'h000
`define DW_DATA_MSB     9
`define DW_DATA_LSB     2
`define DW_FAIL_BIT     1
`define DW_BUSY_BIT     0
// address pointer
`define AP_WIDTH        16
`define AP_RESET        16'h0000
// jtag data register select codes on the dr_select input
`define SEL_NONE        2'h0
`define SEL_DATA        2'h1
`define SEL_ADDR        2'h2
// write modes
`define WM_STORE        3'h0
`define WM_WRITE        3'h1
`define WM_ERASE        3'h2
// read modes
`define RM_PLAIN        4'h0
`define RM_BLOCK        4'h1
`define RM_SINGLE       4'h2
// erase key byte
`define ERASE_KEY       8'hA5
`endif

// ===== jtag_edge_sync.v
// two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
module jtag_edge_sync
(
   input  wire clk,
   input  wire rst_n,
   input  wire async_in,
   output wire level,
   output wire rise,
   output wire fall
);
   reg stage1; // first flop, read only by stage2
   reg stage2; // synchronised level
   reg stage3; // delayed copy for edges
   // ****************************************
   // synchroniser chain
   // ****************************************
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end
      else
      begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end
   assign level = stage2;
   assign rise  = stage2 & ~stage3;
   assign fall  = ~stage2 & stage3;
endmodule

// ===== jtag_flash_data_address_port.v
// jtag flash data window and address pointer with flash sequencer
`timescale 1ns/1ps
`include "jtag_flash_defines.vh"
module jtag_flash_data_address_port
#(
   parameter DW = `DW_WIDTH,
   parameter AW = `AP_WIDTH
)
(
   input  wire          clk,
   input  wire          resetn,
   input  wire          tck,
   input  wire          tdi,
   output wire          tdo,
   input  wire          capture_dr,
   input  wire          shift_dr,
   input  wire          update_dr,
   input  wire [1:0]    dr_select,
   input  wire [2:0]    write_mode,
   input  wire [3:0]    read_mode,
   input  wire          scratch_select,
   output reg           flash_req,
   output reg           flash_write,
   output reg           flash_erase,
   output reg           flash_scratch,
   output reg  [AW-1:0] flash_addr,
   output reg  [7:0]    flash_wdata,
   input  wire          flash_done,
   input  wire          flash_fail,
   input  wire [7:0]    flash_rdata
);
   // ****************************************
   // reset release
   // ****************************************
   reg rst_s1; // first reset flop
   reg rst_n;  // released reset for the design
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // ****************************************
   // pin synchronisers
   // ****************************************
   wire tck_rise;   // tck rising edge seen
   wire tck_fall;   // tck falling edge seen
   wire tdi_s;      // synchronised tdi
   wire cap_s;      // synchronised capture state
   wire shf_s;      // synchronised shift state
   wire upd_s;      // synchronised update state
   wire [4:0] raw_in; // pins besides tck
   wire [4:0] lvl_in; // synchronised pins
   assign raw_in = {tdi, capture_dr, shift_dr, update_dr, 1'b0};
   jtag_edge_sync u_tck
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (tck),
      .level    (),
      .rise     (tck_rise),
      .fall     (tck_fall)
   );
   genvar gi;
   generate
      for (gi = 1; gi < 5; gi = gi + 1)
      begin : g_sync
         jtag_edge_sync u_pin
         (
            .clk      (clk),
            .rst_n    (rst_n),
            .async_in (raw_in[gi]),
            .level    (lvl_in[gi]),
            .rise     (),
            .fall     ()
         );
      end
   endgenerate
   assign lvl_in[0] = 1'b0;
   assign tdi_s = lvl_in[4];
   assign cap_s = lvl_in[3];
   assign shf_s = lvl_in[2];
   assign upd_s = lvl_in[1];

   // ****************************************
   // storage
   // ****************************************
   reg [7:0]    data_byte;  // flash data byte of the window
   reg          fail_flag;  // outcome of previous operation
   reg          busy;       // interface processing a request
   reg [AW-1:0] addr_ptr;   // address pointer
   reg [AW-1:0] shifter;    // jtag shift chain, sized to longer register
   reg          tdo_q;      // tdo driven on falling tck
   reg          upd_d;      // delayed update level
   reg          read_taken; // last read result already shifted out
   reg          inc_pend;   // pointer increments when operation ends
   wire [DW-1:0] window;    // assembled data window
   wire          upd_pulse; // update state entered
   wire          cap_pulse; // capture edge qualified
   wire          is_data;   // data window selected
   assign window    = {data_byte, fail_flag, busy};
   assign upd_pulse = upd_s & ~upd_d & tck_rise;
   assign cap_pulse = cap_s & tck_rise;
   assign is_data   = (dr_select == `SEL_DATA);
   assign tdo       = tdo_q;

   // shift length per selected register
   function [4:0] chain_len;
      input [1:0] sel;
      begin
         chain_len = (sel == `SEL_ADDR) ? 5'h10 : 5'h0A;
      end
   endfunction

   // ****************************************
   // jtag shift chain
   // ****************************************
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shifter <= {AW{1'b0}};
         tdo_q   <= 1'b0;
         upd_d   <= 1'b0;
      end
      else
      begin
         if (tck_rise)
            upd_d <= upd_s;
         if (cap_pulse)
         begin
            // capture loads the selected register, lsb first out
            if (is_data)
               shifter <= {{(AW-DW){1'b0}}, window};
            else
               shifter <= addr_ptr;
         end
         else if (shf_s & tck_rise)
         begin
            // shift in at the top of the selected length
            if (chain_len(dr_select) == 5'h10)
               shifter <= {tdi_s, shifter[AW-1:1]};
            else
               shifter <= {{(AW-DW){1'b0}}, tdi_s, shifter[DW-1:1]};
         end
         if (tck_fall)
            tdo_q <= shifter[0];
      end
   end

   // ****************************************
   // flash sequencer and registers
   // ****************************************
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_byte     <= 8'h00;
         fail_flag     <= 1'b0;
         busy          <= 1'b0;
         addr_ptr      <= `AP_RESET;
         read_taken    <= 1'b1;
         inc_pend      <= 1'b0;
         flash_req     <= 1'b0;
         flash_write   <= 1'b0;
         flash_erase   <= 1'b0;
         flash_scratch <= 1'b0;
         flash_addr    <= {AW{1'b0}};
         flash_wdata   <= 8'h00;
      end
      else
      begin
         flash_req <= 1'b0;
         if (busy & flash_done)
         begin
            busy      <= 1'b0;
            fail_flag <= flash_fail;
            if (!flash_write & !flash_erase)
            begin
               data_byte  <= flash_rdata;
               read_taken <= 1'b0;
            end
            if (inc_pend)
               addr_ptr <= addr_ptr + {{(AW-1){1'b0}}, 1'b1};
            inc_pend <= 1'b0;
         end
         if (cap_pulse & is_data & !busy)
            read_taken <= 1'b1;
         if (upd_pulse & (dr_select == `SEL_ADDR))
            addr_ptr <= shifter;
         else if (upd_pulse & is_data & !busy)
         begin
            // a write replaces the byte and may start an operation
            data_byte <= shifter[`DW_DATA_MSB:`DW_DATA_LSB];
            if ((write_mode == `WM_ERASE)
                & (shifter[`DW_DATA_MSB:`DW_DATA_LSB] != `ERASE_KEY))
            begin
               // wrong key: flash outputs keep standing, failure shows at once
               fail_flag <= 1'b1;
            end
            else if (write_mode == `WM_WRITE | write_mode == `WM_ERASE)
            begin
               // launch write or keyed erase at the pointer
               busy          <= 1'b1;
               flash_req     <= 1'b1;
               flash_write   <= (write_mode == `WM_WRITE);
               flash_erase   <= (write_mode == `WM_ERASE);
               flash_scratch <= scratch_select;
               flash_addr    <= addr_ptr;
               flash_wdata   <= shifter[`DW_DATA_MSB:`DW_DATA_LSB];
               inc_pend      <= (write_mode == `WM_WRITE);
            end
         end
         else if (cap_pulse & is_data & !busy)
         begin
            // a read may launch the next flash read
            if (read_mode == `RM_BLOCK | (read_mode == `RM_SINGLE & read_taken))
            begin
               busy          <= 1'b1;
               flash_req     <= 1'b1;
               flash_write   <= 1'b0;
               flash_erase   <= 1'b0;
               flash_scratch <= scratch_select;
               flash_addr    <= addr_ptr;
               inc_pend      <= 1'b1;
            end
         end
      end
   end
endmodule

// ===== jtag_flash_port_asserts.sv
// concurrent checks on the flash side of the jtag flash port
`timescale 1ns/1ps
module jtag_flash_port_asserts
#(
   parameter AW = 16
)
(
   input wire          clk,
   input wire          resetn,
   input wire          capture_dr,
   input wire          update_dr,
   input wire          flash_req,
   input wire          flash_write,
   input wire          flash_erase,
   input wire [AW-1:0] flash_addr,
   input wire [7:0]    flash_wdata,
   input wire          flash_done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   reg busy_q;   // an operation is out at the flash
   // follows req and done to know when the flash is busy
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         busy_q <= 1'b0;
      else if (flash_req)
         busy_q <= 1'b1;
      else if (flash_done)
         busy_q <= 1'b0;
   end
   req_pulse_a: assert property (flash_req |=> !flash_req) else $error("req not one cycle");
   one_op_a: assert property (flash_req |-> !busy_q) else $error("req while busy");
   addr_hold_a: assert property ($changed(flash_addr) |-> flash_req)
      else $error("address moved without req");
   wdata_hold_a: assert property ($changed(flash_wdata) |-> flash_req)
      else $error("write data moved without req");
   kind_hold_a: assert property ($changed(flash_write) || $changed(flash_erase) |-> flash_req)
      else $error("operation kind moved without req");
   req_cause_a: assert property (flash_req |-> $past(update_dr, 3) || $past(capture_dr, 3))
      else $error("req without capture or update");
   erase_key_a: assert property (flash_req && flash_erase |-> flash_wdata == 8'hA5)
      else $error("erase without key");
   kind_excl_a: assert property (flash_req |-> !(flash_write && flash_erase))
      else $error("write and erase together");
endmodule
bind jtag_flash_data_address_port jtag_flash_port_asserts #(.AW(AW)) u_chk (.clk(clk),
   .resetn(resetn), .capture_dr(capture_dr), .update_dr(update_dr), .flash_req(flash_req),
   .flash_write(flash_write), .flash_erase(flash_erase), .flash_addr(flash_addr),
   .flash_wdata(flash_wdata), .flash_done(flash_done));

// ===== jtag_flash_mem_model.sv
// behavioural flash array that answers the port after a set latency
`timescale 1ns/1ps
module jtag_flash_mem_model
(
   input  wire        clk,
   input  wire        resetn,
   input  wire        flash_req,
   input  wire [15:0] flash_addr,
   input  wire [15:0] lat,
   output reg         flash_done,
   output reg         flash_fail,
   output reg  [7:0]  flash_rdata,
   output reg  [7:0]  n_req
);
   reg [15:0] cnt;   // cycles left on the running operation
   // upper half locked; read data is the address low byte xor 5A
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt <= 16'h0000;
         n_req <= 8'h00;
         flash_done <= 1'b0;
         flash_fail <= 1'b0;
         flash_rdata <= 8'h00;
      end
      else
      begin
         flash_done <= (cnt == 16'h0001);
         flash_fail <= (cnt == 16'h0001) ? flash_addr[15] : ~flash_fail;
         flash_rdata <= (cnt == 16'h0001) ? (flash_addr[7:0] ^ 8'h5A) : ~flash_rdata;
         if (flash_req)
         begin
            cnt <= lat;
            n_req <= n_req + 8'h01;
         end
         else if (cnt != 16'h0000)
            cnt <= cnt - 16'h0001;
      end
   end
endmodule

// ===== jtag_flash_data_address_port_tb.sv
// self-checking bench for the jtag flash data and address port
`timescale 1ns/1ps
`include "jtag_flash_defines.vh"
module jtag_flash_data_address_port_tb;
   reg         clk = 0, resetn = 0, tck = 0, tdi = 0, cap = 0, shf = 0, upd = 0, scr = 0;
   reg  [1:0]  sel = 0;
   reg  [2:0]  wm = 0;
   reg  [3:0]  rm = 0;
   reg  [15:0] lat = 16'h0008;
   reg  [15:0] got;
   wire        tdo, req, wr, er, sc, done, fl;
   wire [15:0] fa;
   wire [7:0]  wd, rd, n_req;
   integer     error_cnt = 0, n_compared = 0;
   always #2 clk = ~clk;
   jtag_flash_data_address_port dut (.clk(clk), .resetn(resetn), .tck(tck), .tdi(tdi),
      .tdo(tdo), .capture_dr(cap), .shift_dr(shf), .update_dr(upd), .dr_select(sel),
      .write_mode(wm), .read_mode(rm), .scratch_select(scr), .flash_req(req),
      .flash_write(wr), .flash_erase(er), .flash_scratch(sc), .flash_addr(fa),
      .flash_wdata(wd), .flash_done(done), .flash_fail(fl), .flash_rdata(rd));
   jtag_flash_mem_model u_mem (.clk(clk), .resetn(resetn), .flash_req(req), .flash_addr(fa),
      .lat(lat), .flash_done(done), .flash_fail(fl), .flash_rdata(rd), .n_req(n_req));
   task tick(input integer n);
      begin repeat (n) @(posedge clk); #1; end
   endtask
   task conclude;
      begin
         $display("compared %0d mismatches %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task check(input [15:0] seen, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp)
         begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one link clock period of about 125 ns
   task pulse;
      begin tick(16); tck = 1; tick(15); tck = 0; end
   endtask
   // capture, shift lsb first, then optional update
   task scan(input [1:0] s, input integer n, input [15:0] din, input u);
      integer i;
      begin
         got = 0; sel = s; cap = 1; pulse; cap = 0; shf = 1;
         // tdo is taken just before the rising link edge, as a host does
         for (i = 0; i < n; i = i + 1)
         begin tdi = din[i]; tick(16); got[i] = tdo; tck = 1; tick(15); tck = 0; end
         shf = 0; upd = u; pulse; upd = 0; tick(4);
      end
   endtask
   // host polls the window until busy clears
   task poll;
      integer k;
      begin
         wm = `WM_STORE; rm = `RM_PLAIN; got = 16'h0001; k = 0;
         while (got[0] !== 1'b0 && k < 40)
         begin scan(`SEL_DATA, 10, 0, 0); k = k + 1; end
         if (got[0] !== 1'b0)
         begin error_cnt = error_cnt + 1; conclude; end
      end
   endtask
   task addr_is(input [15:0] a);
      begin scan(`SEL_ADDR, 16, 0, 0); check(got, a); end
   endtask
   initial
   begin
      repeat (5) @(posedge clk); #1 resetn = 1; tick(4);
      scan(`SEL_DATA, 10, 0, 0); check(got[9:0], `DW_RESET);
      scan(`SEL_ADDR, 16, 16'h0010, 1); check(got, `AP_RESET);
      lat = 16'd600; wm = `WM_WRITE; scan(`SEL_DATA, 10, 16'h00F0, 1);
      check(fa, 16'h0010); check(wd, 8'h3C); check(wr, 1'b1);
      scan(`SEL_DATA, 10, 16'h01DC, 1); check(got[0], 1'b1); check(n_req, 8'h01);
      poll; check(got[9:2], 8'h3C); check(got[1], 1'b0); addr_is(16'h0011);
      lat = 16'h0008; scan(`SEL_ADDR, 16, 16'h8000, 1); wm = `WM_WRITE;
      scan(`SEL_DATA, 10, 16'h0044, 1); poll; check(got[1], 1'b1); addr_is(16'h8001);
      scan(`SEL_ADDR, 16, 16'h0020, 1); rm = `RM_BLOCK; scan(`SEL_DATA, 10, 0, 0);
      poll; check(got[9:2], 8'h7A); check(got[1], 1'b0); addr_is(16'h0021);
      rm = `RM_SINGLE; scan(`SEL_DATA, 10, 0, 0); poll; check(got[9:2], 8'h7B);
      wm = `WM_ERASE; scan(`SEL_DATA, 10, 16'h0044, 1); poll; check(got[1], 1'b1);
      check(n_req, 8'h04); wm = `WM_ERASE; scr = 1; scan(`SEL_DATA, 10, 16'h0294, 1);
      check(er, 1'b1); check(sc, 1'b1); poll; check(got[1], 1'b0); addr_is(16'h0022);
      scr = 0; wm = `WM_STORE; scan(`SEL_DATA, 10, 16'h03FC, 1); scan(`SEL_DATA, 10, 0, 0);
      check(got[9:2], 8'hFF); check(n_req, 8'h05); check(got[0], 1'b0);
      conclude;
   end
endmodule
